// >>> dmad_consts.svh
// constants for the data memory address decode block
`ifndef DMAD_CONSTS_SVH
`define DMAD_CONSTS_SVH
`define DMAD_RAM_BYTES     256
`define DMAD_UPPER_BASE    8'h80
`define DMAD_BANK_TOP      8'h1f
`define DMAD_BIT_BASE      8'h20
`define DMAD_BIT_TOP       8'h2f
`define DMAD_BANK_LSB      3
`define DMAD_PSW_ADDR      8'hd0
`define DMAD_PSW_RS_LSB    3
`define DMAD_SECTOR_BYTES  512
`define DMAD_SECTOR_BITS   9
`define DMAD_PROG_BYTES    8192
`define DMAD_PROG_ABITS    13
`define DMAD_ERASED_BYTE   8'hff
`endif

// >>> dmad_pkg.sv
// types for the data memory address decode block
package dmad_pkg;
   // target selected by the decoder
   typedef enum logic [2:0] {
      DMAD_TGT_RAM = 3'b001,
      DMAD_TGT_SFS = 3'b010,
      DMAD_TGT_NONE = 3'b100
   } dmad_tgt_e;
   // program store state machine
   typedef enum logic [2:0] {
      DMAD_PS_IDLE  = 3'b001,
      DMAD_PS_ERASE = 3'b010,
      DMAD_PS_DONE  = 3'b100
   } dmad_ps_e;
endpackage : dmad_pkg

// >>> dmad_prog_if.sv
// interface between the decoder and the program store
`timescale 1ns/10ps
`default_nettype none
interface dmad_prog_if;
   logic        rd;       // read strobe
   logic        wr;       // byte write strobe
   logic        erase;    // sector erase strobe
   logic [12:0] addr;     // byte address
   logic [7:0]  wdata;    // write data
   logic [7:0]  rdata;    // read data, next cycle
   logic        busy;     // erase in progress
   modport master (output rd, wr, erase, addr, wdata, input rdata, busy);
   modport store  (input rd, wr, erase, addr, wdata, output rdata, busy);
endinterface : dmad_prog_if
`default_nettype wire

// >>> dmad_prog_store.sv
// program store with 512-byte sector erase
`timescale 1ns/10ps
`default_nettype none
`include "dmad_consts.svh"
module dmad_prog_store import dmad_pkg::*; (
   // clock and reset
   input wire logic  MCLK,
   input wire logic  RST,
   // port to the decoder
   dmad_prog_if.store pif
);
   // ****************************************
   // storage and erase walker
   // ****************************************
   logic [7:0] mem_q [`DMAD_PROG_BYTES];      // program bytes
   logic [7:0] mem_d [`DMAD_PROG_BYTES];
   dmad_ps_e   st_q, st_d;                    // erase state
   logic [12:0] ptr_q, ptr_d;                 // erase pointer
   logic [7:0] rd_q, rd_d;                    // read data
   // next state: erase walks one byte a cycle, no external voltage needed
   always_comb begin
      mem_d = mem_q;
      st_d  = st_q;
      ptr_d = ptr_q;
      rd_d  = pif.rd ? mem_q[pif.addr] : rd_q;
      case (st_q)
         DMAD_PS_IDLE: begin
            if (pif.erase) begin
               ptr_d = {pif.addr[12:`DMAD_SECTOR_BITS], 9'h000};
               st_d  = DMAD_PS_ERASE;
            end else if (pif.wr) begin
               mem_d[pif.addr] = mem_q[pif.addr] & pif.wdata;  // write clears bits only
            end
         end
         DMAD_PS_ERASE: begin
            mem_d[ptr_q] = `DMAD_ERASED_BYTE;
            ptr_d = ptr_q + 13'h0001;
            if (ptr_q[8:0] == 9'h1ff) st_d = DMAD_PS_DONE;
         end
         DMAD_PS_DONE: st_d = DMAD_PS_IDLE;
         default: st_d = DMAD_PS_IDLE;
      endcase
   end
   // registers; program contents survive reset
   always_ff @(posedge MCLK) begin
      mem_q <= mem_d;
      rd_q  <= rd_d;
      if (RST) begin
         st_q  <= DMAD_PS_IDLE;
         ptr_q <= 13'h0000;
      end else begin
         st_q  <= st_d;
         ptr_q <= ptr_d;
      end
   end
   assign pif.rdata = rd_q;
   assign pif.busy  = (st_q != DMAD_PS_IDLE);
   // ****************************************
   // checks
   // ****************************************
   property p_erase_len;
      @(posedge MCLK) disable iff (RST)
      (st_q == DMAD_PS_IDLE && pif.erase) |=> (st_q == DMAD_PS_ERASE)[*8];
   endproperty
   a_erase_len: assert property (p_erase_len) else $error("erase ended early");
   c_erase: cover property (@(posedge MCLK) st_q == DMAD_PS_DONE);
endmodule : dmad_prog_store
`default_nettype wire

// >>> dmad_sfs_model.sv
// special function space model on the far side of the decoder
`timescale 1ns/10ps
`default_nettype none
module dmad_sfs_model (
   // clock
   input  wire logic       mclk,
   // port from the decoder
   input  wire logic       sfs_rd,
   input  wire logic       sfs_wr,
   input  wire logic [6:0] sfs_addr,
   input  wire logic [7:0] sfs_wdata,
   output var  logic [7:0] sfs_rdata
);
   // ****************
   // storage
   // ****************
   logic [7:0] mem [128];  // register contents
   logic [7:0] junk_q;     // changes every cycle so stale data matches at most one cycle in 256
   // known start values, no reset on this side
   initial begin
      for (int i = 0; i < 128; i++) begin
         mem[i] = 8'(i) ^ 8'ha5;
      end
      junk_q = 8'h3c;
   end
   // writes land on the edge that sees the strobe
   always_ff @(posedge mclk) begin
      junk_q <= junk_q + 8'h5b;
      if (sfs_wr) begin
         mem[sfs_addr] <= sfs_wdata;
      end
   end
   // read data only valid while the read strobe is up
   always_comb begin
      sfs_rdata = sfs_rd ? mem[sfs_addr] : junk_q;
   end
endmodule : dmad_sfs_model
`default_nettype wire

// >>> dmad_top.sv
// data memory address decode: 256-byte ram, special function space steering, program store
//
// Operation
// - 256-byte RAM, upper half shares special space
// - indirect upper accesses reach upper RAM
// - direct upper accesses except bit writes reach special space
// - lower 128 bytes reachable by both modes
// - lowest 32 bytes form four register banks
// - bytes 0x20-0x2f byte or bit addressable
// - program memory erased in 512-byte sectors
`timescale 1ns/10ps
`default_nettype none
`include "dmad_consts.svh"
module dmad_top import dmad_pkg::*; (
   // clock and reset
   input  wire logic       MCLK,
   input  wire logic       RST,
   // data access request from the core
   input  wire logic       REQ,          // access valid this cycle
   input  wire logic       WR,           // 1 write, 0 read
   input  wire logic       INDIRECT,     // 1 indirect, 0 direct
   input  wire logic       BIT_ACC,      // bit access, addr is a bit address
   input  wire logic       REG_ACC,      // working register access, addr[2:0] = register
   input  wire logic [7:0] ADDR,
   input  wire logic [7:0] WDATA,        // write byte, bit value in WDATA[0]
   // answer, one cycle later for ram, two cycles later for special space reads
   output var  logic [7:0] RDATA,
   output var  logic       RVALID,
   // special function space port
   output var  logic       SFS_RD,
   output var  logic       SFS_WR,
   output var  logic [6:0] SFS_ADDR,
   output var  logic [7:0] SFS_WDATA,
   input  wire logic [7:0] SFS_RDATA,
   // bank in use
   output var  logic [1:0] BANK,
   // program store port
   input  wire logic       PRG_RD,
   input  wire logic       PRG_WR,
   input  wire logic       PRG_ERASE,
   input  wire logic [12:0] PRG_ADDR,
   input  wire logic [7:0] PRG_WDATA,
   output var  logic [7:0] PRG_RDATA,
   output var  logic       PRG_BUSY
);
   // ****************************************
   // decode
   // ****************************************
   logic [7:0] ram_q [`DMAD_RAM_BYTES];   // data ram, size
   logic [7:0] ram_d [`DMAD_RAM_BYTES];
   logic [1:0] bank_q, bank_d;            // status word bank field
   logic [7:0] rdata_q, rdata_d;
   logic       rvalid_q, rvalid_d;
   logic       sfs_rd_q, sfs_rd_d, sfs_wr_q, sfs_wr_d;
   logic [6:0] sfs_addr_q, sfs_addr_d;
   logic [7:0] sfs_wdata_q, sfs_wdata_d;
   logic       sfs_pend_q, sfs_pend_d;    // read answered from sfs data next cycle
   logic       bit_q, bit_d;              // pending read is a bit read
   logic [2:0] bpos_q, bpos_d;
   dmad_tgt_e  tgt;                       // decoded target
   logic [7:0] byte_addr;                 // resolved byte address
   logic [2:0] bpos;                      // bit position for bit access
   logic [7:0] cur;                       // current ram byte
   // resolve address: bank registers and bit region map into ram
   always_comb begin
      bpos = ADDR[2:0];
      if (REG_ACC)
         byte_addr = {3'h0, bank_q, ADDR[2:0]};
      else if (BIT_ACC && !ADDR[7])
         byte_addr = `DMAD_BIT_BASE | {4'h0, ADDR[6:3]};
      else if (BIT_ACC)
         byte_addr = {ADDR[7:3], 3'h0};                          // bit in a special byte
      else
         byte_addr = ADDR;
      if (!REQ)
         tgt = DMAD_TGT_NONE;
      else if (byte_addr[7] && !INDIRECT)
         tgt = DMAD_TGT_SFS;
      else
         tgt = DMAD_TGT_RAM;
      cur = ram_q[byte_addr];
   end
   // next values for ram, answers and special port
   always_comb begin
      ram_d       = ram_q;
      bank_d      = bank_q;
      rdata_d     = rdata_q;
      rvalid_d    = 1'b0;
      sfs_rd_d    = 1'b0;
      sfs_wr_d    = 1'b0;
      sfs_addr_d  = sfs_addr_q;
      sfs_wdata_d = sfs_wdata_q;
      sfs_pend_d  = 1'b0;
      bit_d       = BIT_ACC;
      bpos_d      = bpos;
      if (sfs_pend_q) begin
         // sfs read data arrives now; bit reads take one bit
         rdata_d  = bit_q ? {7'h00, SFS_RDATA[bpos_q]} : SFS_RDATA;
         rvalid_d = 1'b1;
      end
      case (tgt)
         DMAD_TGT_RAM: begin
            if (WR) begin
               if (BIT_ACC) begin
                  ram_d[byte_addr] = cur;
                  ram_d[byte_addr][bpos] = WDATA[0];
               end else begin
                  ram_d[byte_addr] = WDATA;
               end
            end else begin
               rdata_d  = BIT_ACC ? {7'h00, cur[bpos]} : cur;
               rvalid_d = 1'b1;
            end
         end
         DMAD_TGT_SFS: begin
            sfs_addr_d = byte_addr[6:0];
            if (WR && !BIT_ACC) begin
               sfs_wr_d    = 1'b1;
               sfs_wdata_d = WDATA;
               if (byte_addr == `DMAD_PSW_ADDR)
                  bank_d = WDATA[`DMAD_PSW_RS_LSB +: 2];
            end else begin
               // bit writes to special space are read-only here; limitation kept small
               sfs_rd_d   = !WR;
               sfs_pend_d = !WR;
            end
         end
         DMAD_TGT_NONE: ;
         default: ;
      endcase
   end
   // registers; ram contents are not cleared by reset
   always_ff @(posedge MCLK) begin
      ram_q <= ram_d;
      sfs_addr_q  <= sfs_addr_d;
      sfs_wdata_q <= sfs_wdata_d;
      bpos_q <= bpos_d;
      bit_q  <= bit_d;
      if (RST) begin
         bank_q     <= 2'h0;
         rdata_q    <= 8'h00;
         rvalid_q   <= 1'b0;
         sfs_rd_q   <= 1'b0;
         sfs_wr_q   <= 1'b0;
         sfs_pend_q <= 1'b0;
      end else begin
         bank_q     <= bank_d;
         rdata_q    <= rdata_d;
         rvalid_q   <= rvalid_d;
         sfs_rd_q   <= sfs_rd_d;
         sfs_wr_q   <= sfs_wr_d;
         sfs_pend_q <= sfs_pend_d;
      end
   end
   // ****************************************
   // program store
   // ****************************************
   dmad_prog_if pif ();
   logic [7:0] prd_q;   // program read data register
   logic       pbusy_q;
   assign pif.rd    = PRG_RD;
   assign pif.wr    = PRG_WR;
   assign pif.erase = PRG_ERASE;
   assign pif.addr  = PRG_ADDR;
   assign pif.wdata = PRG_WDATA;
   dmad_prog_store u_store (
      .MCLK (MCLK),
      .RST  (RST),
      .pif  (pif.store)
   );
   // outputs straight from flops
   always_ff @(posedge MCLK) begin
      if (RST) begin
         pbusy_q <= 1'b0;
      end else begin
         pbusy_q <= pif.busy;
      end
   end
   always_ff @(posedge MCLK) begin
      prd_q <= pif.rdata;
   end
   assign PRG_RDATA = prd_q;
   assign PRG_BUSY  = pbusy_q;
   assign RDATA     = rdata_q;
   assign RVALID    = rvalid_q;
   assign SFS_RD    = sfs_rd_q;
   assign SFS_WR    = sfs_wr_q;
   assign SFS_ADDR  = sfs_addr_q;
   assign SFS_WDATA = sfs_wdata_q;
   assign BANK      = bank_q;
   // ****************************************
   // checks
   // ****************************************
   property p_direct_upper;
      @(posedge MCLK) disable iff (RST)
      (REQ && !INDIRECT && !REG_ACC && !BIT_ACC && ADDR[7] && !WR) |=> SFS_RD && SFS_ADDR == $past(ADDR[6:0]);
   endproperty
   a_direct_upper: assert property (p_direct_upper) else $error("direct upper not sent to sfs");
   property p_indirect_upper;
      @(posedge MCLK) disable iff (RST)
      (REQ && INDIRECT && !REG_ACC && !BIT_ACC && ADDR[7]) |=> !SFS_RD && !SFS_WR;
   endproperty
   a_indirect_upper: assert property (p_indirect_upper) else $error("indirect upper left ram");
   property p_lower_ram;
      @(posedge MCLK) disable iff (RST)
      (REQ && !WR && !BIT_ACC && !REG_ACC && !ADDR[7]) |=> RVALID && RDATA == $past(ram_q[ADDR]);
   endproperty
   a_lower_ram: assert property (p_lower_ram) else $error("lower ram read wrong");
   property p_ram_write;
      @(posedge MCLK) disable iff (RST)
      (REQ && WR && INDIRECT && !BIT_ACC && !REG_ACC) |=> ram_q[$past(ADDR)] == $past(WDATA);
   endproperty
   a_ram_write: assert property (p_ram_write) else $error("ram write lost");
   property p_bank;
      @(posedge MCLK) disable iff (RST)
      (REQ && REG_ACC && !WR) |=> RDATA == $past(ram_q[{3'h0, bank_q, ADDR[2:0]}]);
   endproperty
   a_bank: assert property (p_bank) else $error("bank register read wrong");
   property p_bit;
      @(posedge MCLK) disable iff (RST)
      (REQ && BIT_ACC && !REG_ACC && !ADDR[7] && !WR) |=> RDATA == {7'h00, $past(ram_q[8'h20 | ADDR[6:3]][ADDR[2:0]])};
   endproperty
   a_bit: assert property (p_bit) else $error("bit read wrong");
   property p_bank_reset;
      @(posedge MCLK) $past(RST) |-> BANK == 2'h0;
   endproperty
   a_bank_reset: assert property (p_bank_reset) else $error("bank not zero after reset");
   property p_busy;
      @(posedge MCLK) disable iff (RST)
      (PRG_ERASE && !PRG_BUSY && !pif.busy) |-> ##2 PRG_BUSY;
   endproperty
   a_busy: assert property (p_busy) else $error("erase busy missing");
   c_sfs_read: cover property (@(posedge MCLK) SFS_RD);
   c_bank3: cover property (@(posedge MCLK) BANK == 2'h3);
   c_bit_write: cover property (@(posedge MCLK) REQ && WR && BIT_ACC && !ADDR[7]);
endmodule : dmad_top
`default_nettype wire

// >>> tb_data_memory_address_decode.sv
// self-checking bench for the data memory address decode block
`timescale 1ns/10ps
`default_nettype none
module tb_data_memory_address_decode;
   // ****************
   // bench signals
   // ****************
   logic        MCLK = 1'b0;
   logic        RST = 1'b1;
   logic        REQ = 1'b0;
   logic        WR = 1'b0;
   logic        INDIRECT = 1'b0;
   logic        BIT_ACC = 1'b0;
   logic        REG_ACC = 1'b0;
   logic [7:0]  ADDR = 8'h00;
   logic [7:0]  WDATA = 8'h00;
   logic [7:0]  RDATA, SFS_WDATA, SFS_RDATA, PRG_RDATA;
   logic        RVALID, SFS_RD, SFS_WR, PRG_BUSY;
   logic [6:0]  SFS_ADDR;
   logic [1:0]  BANK;
   logic        PRG_RD = 1'b0;
   logic        PRG_WR = 1'b0;
   logic        PRG_ERASE = 1'b0;
   logic [12:0] PRG_ADDR = 13'h0000;
   logic [7:0]  PRG_WDATA = 8'h00;
   int          mismatches = 0;
   int          check_count = 0;
   // 50 MHz
   always #10 MCLK = ~MCLK;
   dmad_top u_dmad_top (.MCLK(MCLK), .RST(RST), .REQ(REQ), .WR(WR), .INDIRECT(INDIRECT),
      .BIT_ACC(BIT_ACC), .REG_ACC(REG_ACC), .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA),
      .RVALID(RVALID), .SFS_RD(SFS_RD), .SFS_WR(SFS_WR), .SFS_ADDR(SFS_ADDR),
      .SFS_WDATA(SFS_WDATA), .SFS_RDATA(SFS_RDATA), .BANK(BANK), .PRG_RD(PRG_RD),
      .PRG_WR(PRG_WR), .PRG_ERASE(PRG_ERASE), .PRG_ADDR(PRG_ADDR), .PRG_WDATA(PRG_WDATA),
      .PRG_RDATA(PRG_RDATA), .PRG_BUSY(PRG_BUSY));
   dmad_sfs_model u_dmad_sfs_model (.mclk(MCLK), .sfs_rd(SFS_RD), .sfs_wr(SFS_WR),
      .sfs_addr(SFS_ADDR), .sfs_wdata(SFS_WDATA), .sfs_rdata(SFS_RDATA));
   // ****************
   // tasks
   // ****************
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out
   // a wait that ran out ends the run
   task automatic hang;
      mismatches++;
      close_out();
   endtask : hang
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one data access; reads wait a bounded time for the answer
   task automatic acc(input logic w, i, b, r, input logic [7:0] a, d, output logic [7:0] q);
      int n;
      @(negedge MCLK);
      REQ = 1'b1;
      WR = w;
      INDIRECT = i;
      BIT_ACC = b;
      REG_ACC = r;
      ADDR = a;
      WDATA = d;
      @(negedge MCLK);
      REQ = 1'b0;
      n = 0;
      while (!w && RVALID !== 1'b1 && n < 8) begin
         @(negedge MCLK);
         n++;
      end
      if (!w && RVALID !== 1'b1) hang();
      q = RDATA;
   endtask : acc
   // program store strobe: 0 read, 1 write, 2 erase; read data two cycles on
   task automatic prg(input int op, input logic [12:0] a, input logic [7:0] d, output logic [7:0] q);
      @(negedge MCLK);
      PRG_RD = (op == 0);
      PRG_WR = (op == 1);
      PRG_ERASE = (op == 2);
      PRG_ADDR = a;
      PRG_WDATA = d;
      @(negedge MCLK);
      {PRG_RD, PRG_WR, PRG_ERASE} = 3'b000;
      repeat (2) @(negedge MCLK);
      q = PRG_RDATA;
   endtask : prg
   // expected byte after a bit write
   function automatic logic [7:0] bit_exp(logic [7:0] old, logic [7:0] ba, logic v);
      bit_exp = old;
      bit_exp[ba[2:0]] = v;
   endfunction : bit_exp
   // ****************
   // main sequence
   // ****************
   initial begin
      logic [7:0] q, a, d;
      int n;
      n = $urandom(32'hf8d28aa2);
      repeat (2) @(posedge MCLK);
      @(negedge MCLK);
      RST = 1'b0;
      chk({6'h0, BANK}, 8'h00);
      chk({7'h0, RVALID}, 8'h00);
      // random traffic on the dual-mapped upper half and the lower half
      for (int k = 0; k < 16; k++) begin
         a = 8'h80 | 8'($urandom_range(0, 8'h6f));
         d = 8'($urandom);
         acc(1, 1, 0, 0, a, d, q);
         acc(1, 0, 0, 0, a, ~d, q);
         acc(0, 1, 0, 0, a, 8'h00, q);
         chk(q, d);
         acc(0, 0, 0, 0, a, 8'h00, q);
         chk(q, ~d);
         a = 8'($urandom_range(8'h30, 8'h7f));
         acc(1, 0, 0, 0, a, d, q);
         acc(0, 1, 0, 0, a, 8'h00, q);
         chk(q, d);
      end
      // every bank, register picked through the status word field
      for (int k = 0; k < 4; k++) begin
         acc(1, 0, 0, 0, 8'hd0, 8'(k << 3), q);
         chk({6'h0, BANK}, 8'(k));
         acc(1, 0, 0, 1, 8'(k + 4), 8'h40 + 8'(k), q);
         acc(0, 1, 0, 0, 8'(k * 8 + k + 4), 8'h00, q);
         chk(q, 8'h40 + 8'(k));
         // read back through the working register path of the same bank
         acc(0, 0, 0, 1, 8'(k + 4), 8'h00, q);
         chk(q, 8'h40 + 8'(k));
      end
      // bits 0x0d and 0x7f of the bit region, set into 0x00 and clear from 0xff
      for (int k = 0; k < 2; k++) begin
         a = k ? 8'h7f : 8'h0d;
         d = k ? 8'hff : 8'h00;
         acc(1, 0, 0, 0, 8'h20 + 8'(a[6:3]), d, q);
         acc(1, 0, 1, 0, a, 8'(k == 0), q);
         acc(0, 1, 0, 0, 8'h20 + 8'(a[6:3]), 8'h00, q);
         chk(q, bit_exp(d, a, k == 0));
         // the same bit read back as a single bit
         acc(0, 0, 1, 0, a, 8'h00, q);
         chk(q, {7'h00, k == 0});
      end
      // a bit of a special byte is read through the base byte of its group of eight
      acc(1, 0, 0, 0, 8'h80, 8'h20, q);
      acc(0, 0, 1, 0, 8'h85, 8'h00, q);
      chk(q, 8'h01);
      acc(0, 0, 1, 0, 8'h84, 8'h00, q);
      chk(q, 8'h00);
      // reset in mid-run returns to bank zero
      @(negedge MCLK);
      RST = 1'b1;
      @(negedge MCLK);
      RST = 1'b0;
      chk({6'h0, BANK}, 8'h00);
      // sector erase, with a write that must be ignored while busy
      prg(2, 13'h0200, 8'h00, q);
      n = 0;
      while (PRG_BUSY !== 1'b1 && n < 4) begin
         @(negedge MCLK);
         n++;
      end
      if (n == 4) hang();
      prg(1, 13'h0201, 8'h00, q);
      n = 4;
      while (PRG_BUSY === 1'b1 && n < 600) begin
         @(negedge MCLK);
         n++;
      end
      if (n == 600) hang();
      chk(8'(n >= 510 && n <= 518), 8'h01);
      prg(0, 13'h0200, 8'h00, q);
      chk(q, 8'hff);
      prg(0, 13'h0201, 8'h00, q);
      chk(q, 8'hff);
      prg(1, 13'h03ff, 8'h5a, q);
      prg(1, 13'h03ff, 8'h0f, q);
      prg(0, 13'h03ff, 8'h00, q);
      chk(q, 8'h0a);
      close_out();
   end
endmodule : tb_data_memory_address_decode
`default_nettype wire
